// ---- verilog/sram_port_cfg.svh ----
`ifndef SRAM_PORT_CFG_SVH
`define SRAM_PORT_CFG_SVH

// Rate of the block's own clock, in nanoseconds per cycle.
`define CLK_PERIOD_NS 100

// Least time the input timing clock must stand still to drop the lock.
`define KSTATIC_NS 30

// That least time in cycles, rounded up and never below one cycle.
`define KSTATIC_CYC (((`KSTATIC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) \
  < 1 ? 1 : ((`KSTATIC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

// Input timing clock rising edges needed before the lock is reported.
`define DLL_LOCK_CYCLES 11'h400

// Width of the lock counter.
`define LOCK_CNT_W 11

// Index of the last beat of a four beat burst.
`define LAST_BEAT 2'h3

// Index of the first beat of a burst.
`define FIRST_BEAT 2'h0

// Step of the burst counter.
`define BURST_STEP 2'h1

`endif

// ---- verilog/sram_port_pkg.sv ----
package sram_port_pkg;

  // Burst engine states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } burst_state_e;

  // The four timing clocks as seen from the block's own clock.
  typedef struct packed {
    logic in_pos;
    logic in_neg;
    logic out_pos;
    logic out_neg;
  } link_clk_s;

endpackage

// ---- verilog/sram_store.sv ----
`timescale 1ns/100ps
// Word store with per-lane write enables and a registered read port.
module sram_store #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 36,
  parameter int MASK_W = 4
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [MASK_W-1:0] wr_lane,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  // Bits per write lane.
  localparam int LANE_W = DATA_W / MASK_W;

  // The array itself; it has no reset, like the cells it stands for.
  logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];

  // Each lane is written on its own, so masked lanes keep old contents.
  for (genvar g = 0; g < MASK_W; g++) begin : g_lane
    always_ff @(posedge clock) begin
      if (wr_en && wr_lane[g]) begin
        mem[wr_addr][g*LANE_W +: LANE_W] <= wr_data[g*LANE_W +: LANE_W];
      end
    end
  end

  // Read data leave from a register one cycle after the address.
  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// ---- verilog/ddr_sram_burst_port.sv ----
`timescale 1ns/100ps
// Operation
// - Address and command taken on input clock rise
// - Write data and masks taken on both edges
// - Reads launch on output clocks, else input clocks
// - Returned strobes move with every read beat
// - First word from address, then burst counter
// - Data outputs released one cycle after idle
// - Slower clocking than the maximum still works
// - Static input clock drops lock, relock follows
`include "sram_port_cfg.svh"
module ddr_sram_burst_port
  import sram_port_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 36,
  parameter int MASK_W = 4,
  parameter int HALF_MAX = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_clk_pos,
  input wire logic in_clk_neg,
  input wire logic out_clk_pos,
  input wire logic out_clk_neg,
  input wire logic transfer_strobe_n,
  input wire logic read_select,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [MASK_W-1:0] byte_write_mask,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic returned_strobe_pos,
  output logic returned_strobe_neg,
  output logic dll_locked
);

  // Width of the synchronised command and data pins.
  localparam int PIN_W = 2 + ADDR_W + MASK_W + DATA_W;
  // Cycles without an input clock edge that count as a stopped clock.
  localparam int STATIC_LIMIT = HALF_MAX + `KSTATIC_CYC;
  // Width of the stopped clock counter.
  localparam int STATIC_W = $clog2(STATIC_LIMIT + 1);

  // Advance the low two address bits, wrapping inside the burst.
  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [ADDR_W-1:0] a
  );
    next_addr = {a[ADDR_W-1:2], a[1:0] + `BURST_STEP};
  endfunction

  link_clk_s clk_m_q; // First synchroniser stage, read only by clk_s_q.
  link_clk_s clk_s_q; // Synchronised timing clocks.
  link_clk_s clk_p_q; // Previous sample, for edge finding.
  logic [PIN_W-1:0] pin_m_q; // First stage of the pin synchroniser.
  logic [PIN_W-1:0] pin_s_q; // Pins, aligned with the clock samples.

  // Every outside signal except the clock and rst passes two flip-flops before any logic sees it.
  always_ff @(posedge clock) begin
    if (rst) begin
      clk_m_q <= '0;
      clk_s_q <= '0;
      clk_p_q <= '0;
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      clk_m_q <= {in_clk_pos, in_clk_neg, out_clk_pos, out_clk_neg};
      clk_s_q <= clk_m_q;
      clk_p_q <= clk_s_q;
      pin_m_q <= {transfer_strobe_n, read_select, addr, byte_write_mask,
                  dq_in};
      pin_s_q <= pin_m_q;
    end
  end

  logic strobe_s; // Synchronised transfer strobe, active low.
  logic rsel_s; // Synchronised direction select, high for read.
  logic [ADDR_W-1:0] addr_s; // Synchronised address.
  logic [MASK_W-1:0] mask_s; // Synchronised write mask, active low.
  logic [DATA_W-1:0] data_s; // Synchronised write data.
  assign {strobe_s, rsel_s, addr_s, mask_s, data_s} = pin_s_q;

  // Edges are found by sampling, so any slower link rate works as well.
  logic k_rise; // Positive input clock rose.
  logic kn_rise; // Negative input clock rose.
  logic k_move; // Positive input clock changed either way.
  logic use_k; // Both output clocks held high.
  logic launch_pos; // Launch edge for even read beats.
  logic launch_neg; // Launch edge for odd read beats.
  assign k_rise = clk_s_q.in_pos & ~clk_p_q.in_pos;
  assign kn_rise = clk_s_q.in_neg & ~clk_p_q.in_neg;
  assign k_move = clk_s_q.in_pos ^ clk_p_q.in_pos;
  assign use_k = clk_s_q.out_pos & clk_s_q.out_neg;
  // With the output clocks tied high the input clocks take their place.
  assign launch_pos = use_k ? k_rise :
                      (clk_s_q.out_pos & ~clk_p_q.out_pos);
  assign launch_neg = use_k ? kn_rise :
                      (clk_s_q.out_neg & ~clk_p_q.out_neg);

  burst_state_e st_q, st_d; // Burst engine state.
  logic [1:0] beat_q, beat_d; // Beat within the burst.
  logic [ADDR_W-1:0] addr_q, addr_d; // Burst counter address.
  logic settle_q, settle_d; // Prefetched read word is valid.
  logic oe_q, oe_d; // Data output enable.
  logic idle_q, idle_d; // Last sampled cycle was an idle cycle.
  logic [DATA_W-1:0] dout_q, dout_d; // Launched read word.
  logic sp_q, sp_d; // Positive returned strobe.
  logic sn_q, sn_d; // Negative returned strobe.
  logic wbeat; // A write beat edge for the current beat.
  logic rbeat; // A read beat launch for the current beat.
  logic wr_en; // Store the current write beat.
  logic [MASK_W-1:0] wr_lane; // Lanes to store, active high.
  logic [DATA_W-1:0] rd_data; // Prefetched word at addr_q.

  // Even beats ride the positive edge, odd beats the negative one.
  assign wbeat = beat_q[0] ? kn_rise : k_rise;
  // The prefetch needs one cycle, so a launch edge that comes before it is ready is ignored.
  assign rbeat = settle_q & (beat_q[0] ? launch_neg : launch_pos);
  // Masks are active low, so a low bit lets its lane through.
  assign wr_lane = ~mask_s;

  // Next values of the burst engine, data path and strobes.
  always_comb begin
    st_d = st_q;
    beat_d = beat_q;
    addr_d = addr_q;
    settle_d = (st_q == ST_READ);
    oe_d = oe_q;
    idle_d = idle_q;
    dout_d = dout_q;
    sp_d = sp_q;
    sn_d = sn_q;
    wr_en = 1'b0;
    // Each positive input edge classifies the cycle as idle or not.
    if (k_rise) begin
      idle_d = strobe_s;
      // One cycle after an idle cycle the bus is let go.
      if (idle_q && st_q != ST_READ) begin
        oe_d = 1'b0;
      end
    end
    case (st_q)
      ST_IDLE: begin
        // Commands are sampled only on the positive input edge.
        if (k_rise && !strobe_s) begin
          addr_d = addr_s;
          beat_d = `FIRST_BEAT;
          if (rsel_s) begin
            st_d = ST_READ;
          end else begin
            st_d = ST_WRITE;
            // Releasing at once keeps a missing idle cycle harmless.
            oe_d = 1'b0;
          end
        end
      end
      ST_WRITE: begin
        // Each beat stores its lanes and steps the burst counter.
        if (wbeat) begin
          wr_en = 1'b1;
          addr_d = next_addr(addr_q);
          beat_d = beat_q + `BURST_STEP;
          if (beat_q == `LAST_BEAT) begin
            st_d = ST_IDLE;
          end
        end
      end
      ST_READ: begin
        // Word, enable and strobes change on the same launch.
        if (rbeat) begin
          dout_d = rd_data;
          oe_d = 1'b1;
          sp_d = ~beat_q[0];
          sn_d = beat_q[0];
          addr_d = next_addr(addr_q);
          beat_d = beat_q + `BURST_STEP;
          if (beat_q == `LAST_BEAT) begin
            st_d = ST_IDLE;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Registers of the burst engine.
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= ST_IDLE;
      beat_q <= `FIRST_BEAT;
      addr_q <= '0;
      settle_q <= 1'b0;
      oe_q <= 1'b0;
      idle_q <= 1'b0;
      dout_q <= '0;
      sp_q <= 1'b0;
      sn_q <= 1'b1;
    end else begin
      st_q <= st_d;
      beat_q <= beat_d;
      addr_q <= addr_d;
      settle_q <= settle_d;
      oe_q <= oe_d;
      idle_q <= idle_d;
      dout_q <= dout_d;
      sp_q <= sp_d;
      sn_q <= sn_d;
    end
  end

  logic [STATIC_W-1:0] static_cnt_q, static_cnt_d; // Cycles without edge.
  logic [`LOCK_CNT_W-1:0] lock_cnt_q, lock_cnt_d; // Edges since relock.
  logic locked_q, locked_d; // Lock reported.
  logic static_trip; // Input clock has stood still long enough.
  assign static_trip = (static_cnt_q == STATIC_LIMIT[STATIC_W-1:0]);

  // Lock tracking; the sampled clock cannot resolve less than a cycle,
  // so a stop is only seen beyond the longest expected half period.
  always_comb begin
    static_cnt_d = static_cnt_q;
    lock_cnt_d = lock_cnt_q;
    locked_d = locked_q;
    if (k_move) begin
      static_cnt_d = '0;
    end else if (!static_trip) begin
      static_cnt_d = static_cnt_q + 1'b1;
    end
    if (static_trip) begin
      lock_cnt_d = '0;
      locked_d = 1'b0;
    end else if (k_rise && !locked_q) begin
      lock_cnt_d = lock_cnt_q + 1'b1;
      if (lock_cnt_q == `DLL_LOCK_CYCLES - 1'b1) begin
        locked_d = 1'b1;
      end
    end
  end

  // Registers of the lock tracker.
  always_ff @(posedge clock) begin
    if (rst) begin
      static_cnt_q <= '0;
      lock_cnt_q <= '0;
      locked_q <= 1'b0;
    end else begin
      static_cnt_q <= static_cnt_d;
      lock_cnt_q <= lock_cnt_d;
      locked_q <= locked_d;
    end
  end

  // Storage array; reads always prefetch the burst counter address.
  sram_store #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .MASK_W(MASK_W)
  ) u_store (
    .clock(clock),
    .wr_en(wr_en),
    .wr_addr(addr_q),
    .wr_data(data_s),
    .wr_lane(wr_lane),
    .rd_addr(addr_q),
    .rd_data(rd_data)
  );

  assign dq_out = dout_q;
  assign dq_oe = oe_q;
  assign returned_strobe_pos = sp_q;
  assign returned_strobe_neg = sn_q;
  assign dll_locked = locked_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // One launched read beat.
  sequence s_read_launch;
    st_q == ST_READ && rbeat;
  endsequence

  // A command cycle on the positive input edge.
  sequence s_command;
    k_rise && st_q == ST_IDLE && !strobe_s;
  endsequence

  a_cmd_taken: assert property (s_command |=> st_q != ST_IDLE)
    else $error("command on input clock edge was not taken");
  a_cmd_only_k: assert property (st_q == ST_IDLE && !k_rise
    |=> st_q == ST_IDLE)
    else $error("burst started away from input clock edge");
  a_write_edge: assert property (wr_en |-> (beat_q[0] ? kn_rise : k_rise))
    else $error("write beat stored on the wrong edge");
  a_write_lanes: assert property (wr_en |-> wr_lane == ~mask_s)
    else $error("write lanes do not follow the mask");
  a_launch_ref: assert property (s_read_launch and use_k
    |-> (beat_q[0] ? kn_rise : k_rise))
    else $error("read launched off the input clocks");
  a_read_data: assert property (s_read_launch
    |=> dq_out == $past(rd_data) && dq_oe)
    else $error("read beat did not launch the prefetched word");
  a_addr_step: assert property (s_read_launch
    |=> addr_q[1:0] == $past(addr_q[1:0]) + `BURST_STEP)
    else $error("burst counter did not step");
  a_strobe_align: assert property (s_read_launch
    |=> returned_strobe_pos == !$past(beat_q[0])
        && returned_strobe_neg != returned_strobe_pos)
    else $error("returned strobes out of step with data");
  a_oe_release: assert property (k_rise && idle_q && st_q != ST_READ
    |=> !dq_oe)
    else $error("outputs not released after idle cycle");
  a_dll_reset: assert property (static_trip |=> !dll_locked)
    else $error("lock kept while input clock stood still");
  a_lock_count: assert property ($rose(locked_q)
    |-> $past(lock_cnt_q) == `DLL_LOCK_CYCLES - 1'b1)
    else $error("lock reported at the wrong edge count");

endmodule

// ---- verification/ctrl_model.sv ----
`timescale 1ns/100ps
// Behavioural memory controller: runs the timing clocks and drives bursts.
module ctrl_model #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 36,
  parameter int MASK_W = 4
) (
  input wire logic clock,
  input wire logic hold_k,
  input wire logic c_high,
  output logic in_clk_pos,
  output logic in_clk_neg,
  output logic out_clk_pos,
  output logic out_clk_neg,
  output logic transfer_strobe_n,
  output logic read_select,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq_in,
  output logic [MASK_W-1:0] byte_write_mask
);
  // Phase within one link period of eight system cycles.
  int cnt = 0;

  // Quiet pins at time zero; the strobe stays high between commands.
  initial begin
    in_clk_pos = 1'b0;
    in_clk_neg = 1'b1;
    out_clk_pos = 1'b0;
    out_clk_neg = 1'b1;
    transfer_strobe_n = 1'b1;
    read_select = 1'b1;
    addr = '0;
    dq_in = '0;
    byte_write_mask = '1;
  end

  // The link clock runs free; holding it still must drop the lock.
  always @(posedge clock) begin
    if (!hold_k) cnt <= (cnt + 1) % 8;
  end

  // Output clocks follow the input pair unless both are tied high.
  always @(posedge clock) begin
    #1;
    in_clk_pos = (cnt < 4);
    in_clk_neg = (cnt >= 4);
    out_clk_pos = c_high | (cnt < 4);
    out_clk_neg = c_high | (cnt >= 4);
  end

  // Pins change one step after a phase edge, well away from link edges.
  task automatic wait_cnt(input int n);
    do begin
      @(posedge clock);
      #1;
    end while (cnt != n);
  endtask

  // Command one cycle before the rise, held until it has been seen.
  task automatic command(input logic rd, input logic [ADDR_W-1:0] a);
    wait_cnt(7);
    transfer_strobe_n = 1'b0;
    read_select = rd;
    addr = a;
    wait_cnt(3);
    // The strobe returns high, so every command is followed by idle cycles.
    transfer_strobe_n = 1'b1;
    read_select = 1'b1;
    addr = ~a;
  endtask

  // Read burst: only the command is ours, the beats come back.
  task automatic read_burst(input logic [ADDR_W-1:0] a);
    command(1'b1, a);
  endtask

  // Write burst: beats land on the next K, /K, K, /K rises.
  task automatic write_burst(input logic [ADDR_W-1:0] a,
                             input logic [4*DATA_W-1:0] d,
                             input logic [4*MASK_W-1:0] m);
    command(1'b0, a);
    // Garbage with open lanes at the /K rise beside the command.
    dq_in = ~dq_in;
    byte_write_mask = '0;
    for (int b = 0; b < 4; b++) begin
      wait_cnt(b[0] ? 3 : 7);
      dq_in = d[b*DATA_W +: DATA_W];
      byte_write_mask = m[b*MASK_W +: MASK_W];
    end
    // Released data shows the inverse, never a stale copy.
    wait_cnt(7);
    dq_in = ~dq_in;
    byte_write_mask = '1;
  endtask
endmodule

// ---- verification/test_ddr_sram_burst_port.sv ----
`timescale 1ns/100ps
// Self-checking bench for the burst port driven by the controller model.
module test_ddr_sram_burst_port;
  logic clock, rst, hold_k, c_high;
  logic in_clk_pos, in_clk_neg, out_clk_pos, out_clk_neg;
  logic transfer_strobe_n, read_select, dq_oe, dll_locked;
  logic returned_strobe_pos, returned_strobe_neg;
  logic [7:0] addr;
  logic [35:0] dq_in, dq_out;
  logic [3:0] byte_write_mask;
  logic [35:0] mem_exp [256]; // Contents the bench expects.
  int fail_count = 0;
  int num_checks = 0;

  // System clock of 100 ns.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Small address width keeps the store short in simulation.
  ddr_sram_burst_port #(.ADDR_W(8), .HALF_MAX(16)) ddr_sram_burst_port_i (
    .clock(clock), .rst(rst), .in_clk_pos(in_clk_pos),
    .in_clk_neg(in_clk_neg), .out_clk_pos(out_clk_pos),
    .out_clk_neg(out_clk_neg), .transfer_strobe_n(transfer_strobe_n),
    .read_select(read_select), .addr(addr), .dq_in(dq_in),
    .byte_write_mask(byte_write_mask), .dq_out(dq_out), .dq_oe(dq_oe),
    .returned_strobe_pos(returned_strobe_pos),
    .returned_strobe_neg(returned_strobe_neg), .dll_locked(dll_locked));

  ctrl_model #(.ADDR_W(8)) ctrl_model_i (
    .clock(clock), .hold_k(hold_k), .c_high(c_high),
    .in_clk_pos(in_clk_pos), .in_clk_neg(in_clk_neg),
    .out_clk_pos(out_clk_pos), .out_clk_neg(out_clk_neg),
    .transfer_strobe_n(transfer_strobe_n), .read_select(read_select),
    .addr(addr), .dq_in(dq_in), .byte_write_mask(byte_write_mask));

  // Count every comparison and report each mismatch.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One cycle, landing just after the edge so outputs have settled.
  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // Write through the model and merge unmasked lanes into the copy.
  task automatic do_write(input logic [7:0] a, input logic [143:0] d,
                          input logic [15:0] m);
    logic [7:0] ba;
    ctrl_model_i.write_burst(a, d, m);
    for (int b = 0; b < 4; b++) begin
      ba = {a[7:2], a[1:0] + 2'(b)};
      for (int l = 0; l < 4; l++) begin
        if (!m[b*4+l]) mem_exp[ba][l*9 +: 9] = d[b*36+l*9 +: 9];
      end
    end
  endtask

  // Each beat is seen as a change of the positive strobe.
  task automatic read_check(input logic [7:0] a);
    logic prev;
    int n;
    logic [7:0] ba;
    ctrl_model_i.read_burst(a);
    for (int b = 0; b < 4; b++) begin
      prev = returned_strobe_pos;
      n = 0;
      while (returned_strobe_pos === prev && n < 40) begin
        step();
        n++;
      end
      ba = {a[7:2], a[1:0] + 2'(b)};
      check(dq_out, mem_exp[ba]);
      check({returned_strobe_pos, returned_strobe_neg},
            b[0] ? 2'h1 : 2'h2);
      check(dq_oe, 1'h1);
    end
    n = 0;
    while (dq_oe === 1'b1 && n < 24) begin
      step();
      n++;
    end
    check(dq_oe, 1'h0);
    // Idle cycles carry read select high, yet nothing may start.
    prev = returned_strobe_pos;
    repeat (24) step();
    check(returned_strobe_pos, prev);
  endtask

  // No traffic until the lock is reported, and not before 1024 rises.
  task automatic test_lock();
    int n;
    n = 0;
    repeat (1020) @(posedge in_clk_pos);
    step();
    check(dll_locked, 1'h0);
    while (dll_locked !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    check(dll_locked, 1'h1);
  endtask

  // Wrapping burst start, then a read from the base of the group.
  task automatic test_full_burst();
    do_write(8'h12, {36'hC_3C3C_3C3C, 36'h9_0F0F_0F0F, 36'h6_1234_5678,
                     36'hA_5A5A_A5A5}, 16'h0000);
    read_check(8'h12);
    read_check(8'h10);
  endtask

  // Lanes masked per beat; the read launches from the input clocks.
  task automatic test_masked_burst();
    do_write(8'h11, {36'h1_1111_1111, 36'h2_2222_2222, 36'h3_3333_3333,
                     36'h4_4444_4444}, 16'h0F5A);
    c_high = 1'b1;
    read_check(8'h13);
    c_high = 1'b0;
  endtask

  // A still input clock drops the lock; it must relock afterwards.
  task automatic test_clock_stop();
    int n;
    n = 0;
    hold_k = 1'b1;
    repeat (30) step();
    check(dll_locked, 1'h0);
    hold_k = 1'b0;
    repeat (100) step();
    check(dll_locked, 1'h0);
    while (dll_locked !== 1'b1 && n < 9000) begin
      step();
      n++;
    end
    check(dll_locked, 1'h1);
    read_check(8'h11);
  endtask

  // Whole run is about 17000 cycles; allow well beyond it.
  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    hold_k = 1'b0;
    c_high = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    test_lock();
    test_full_burst();
    test_masked_burst();
    test_clock_stop();
    report_and_stop();
  end
endmodule
